// ==== core/flag_sync.sv ====
/*
  Two-stage level synchroniser, with no edge catching, for source request lines
  that may come from another domain. Assumes aclk is the bank's clock.
*/
`timescale 1ns/1ps
`default_nettype none
module flag_sync #(
  parameter int W = 22
) (
  // Clock and reset
  input  wire logic         aclk,
  input  wire logic         aresetn,
  // Raw request lines
  input  wire logic [W-1:0] raw,
  // Synchronised levels
  output logic      [W-1:0] lvl
);
  logic [W-1:0] meta_r;
  // First stage is read only by the second
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      meta_r <= '0;
      lvl    <= '0;
    end else begin
      meta_r <= raw;
      lvl    <= meta_r;
    end
  end
endmodule : flag_sync
`default_nettype wire

// ==== core/irq_bank_consts.svh ====
/*
  Offsets, field positions, reset values and write masks of the enable and
  priority bank. Included by the package users; holds definitions only.
*/
`ifndef IRQ_BANK_CONSTS_SVH
`define IRQ_BANK_CONSTS_SVH

// Byte offsets on the register bus
`define OFF_ENABLE_FOUR    8'h00
`define OFF_PRIO_ZERO      8'h04
`define OFF_PRIO_ONE       8'h08
`define OFF_PRIO_TWO       8'h0c
`define OFF_PRIO_THREE     8'h10
`define OFF_PRIO_FOUR      8'h14
`define OFF_PRIO_FIVE      8'h18
`define OFF_FLAG_STATUS    8'h1c
`define OFF_FLAG_MASK      8'h20
`define OFF_REQ_STATUS     8'h24

// Enable bit positions
`define EN_FAULT_B_BIT     10
`define EN_ERROR_B_BIT     9
`define EN_SERIAL_ERR_BIT  1

// Implemented bit masks
`define ENABLE_FOUR_MASK   16'h0602
`define PRIO_ZERO_MASK     16'h7777
`define PRIO_ONE_MASK      16'h7770
`define PRIO_TWO_MASK      16'h7777
`define PRIO_THREE_MASK    16'h0077
`define PRIO_FOUR_MASK     16'h7077
`define PRIO_FIVE_MASK     16'h7707

// Reset values: priority fields 100, enables 0
`define ENABLE_FOUR_RST    16'h0000
`define PRIO_ALL_RST       16'h4444

// Number of interrupt sources
`define NUM_SRC            22
`define BUS_OKAY           2'b00
`define BUS_DECERR         2'b11

`endif

// ==== core/irq_bank_pkg.sv ====
/*
  Types shared by the enable and priority bank.
  Assumes nothing of its surroundings.
*/
`default_nettype none
package irq_bank_pkg;
  typedef logic [2:0]  prio_t;
  typedef logic [15:0] reg16_t;
endpackage : irq_bank_pkg
`default_nettype wire

// ==== core/irq_enable_priority_bank.sv ====
/*
  Enable and priority bank of the interrupt controller, with an AXI4-Lite
  slave, source flags, a status/mask interrupt and per-source requests.
  Assumes one clock aclk, synchronous active-low reset, raw request lines.
*/
// The AXI4-Lite slave port and the register offsets were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
`include "irq_bank_consts.svh"
module irq_enable_priority_bank #(
  parameter int NSRC = `NUM_SRC
) (
  // Clock and reset
  input  wire logic            aclk,
  input  wire logic            aresetn,
  // AXI4-Lite write address
  input  wire logic            s_axi_awvalid,
  output logic                 s_axi_awready,
  input  wire logic [7:0]      s_axi_awaddr,
  // AXI4-Lite write data
  input  wire logic            s_axi_wvalid,
  output logic                 s_axi_wready,
  input  wire logic [31:0]     s_axi_wdata,
  input  wire logic [3:0]      s_axi_wstrb,
  // AXI4-Lite write response
  output logic                 s_axi_bvalid,
  input  wire logic            s_axi_bready,
  output logic [1:0]           s_axi_bresp,
  // AXI4-Lite read address
  input  wire logic            s_axi_arvalid,
  output logic                 s_axi_arready,
  input  wire logic [7:0]      s_axi_araddr,
  // AXI4-Lite read data
  output logic                 s_axi_rvalid,
  input  wire logic            s_axi_rready,
  output logic [31:0]          s_axi_rdata,
  output logic [1:0]           s_axi_rresp,
  // Peripheral request lines, one per source
  input  wire logic [NSRC-1:0] src_raw,
  // Requests and levels toward the core
  output logic [NSRC-1:0]      core_req,
  output logic [3*NSRC-1:0]    core_level,
  // Level interrupt
  output logic                 irq
);
  import irq_bank_pkg::*;

  // Sources 0..18 own a priority field here; 19..21 own an enable bit here
  reg16_t enable_four_r;
  reg16_t prio_r [6];
  logic [NSRC-1:0] flag_r;
  logic [NSRC-1:0] mask_r;
  logic [NSRC-1:0] lvl;
  logic [NSRC-1:0] lvl_d_r;
  logic [NSRC-1:0] en_vec;
  prio_t           prio_vec [NSRC];
  logic [NSRC-1:0] req_w;
  prio_t           level_w  [NSRC];

  // Incoming lines may come from other domains
  flag_sync #(.W(NSRC)) u_sync (
    .aclk    (aclk),
    .aresetn (aresetn),
    .raw     (src_raw),
    .lvl     (lvl)
  );

  // Field extraction per source
  always_comb begin
    prio_vec[0]  = prio_r[0][14:12];
    prio_vec[1]  = prio_r[0][10:8];
    prio_vec[2]  = prio_r[0][6:4];
    prio_vec[3]  = prio_r[0][2:0];
    prio_vec[4]  = prio_r[1][14:12];
    prio_vec[5]  = prio_r[1][10:8];
    prio_vec[6]  = prio_r[1][6:4];
    prio_vec[7]  = prio_r[2][14:12];
    prio_vec[8]  = prio_r[2][10:8];
    prio_vec[9]  = prio_r[2][6:4];
    prio_vec[10] = prio_r[2][2:0];
    prio_vec[11] = prio_r[3][6:4];
    prio_vec[12] = prio_r[3][2:0];
    prio_vec[13] = prio_r[4][14:12];
    prio_vec[14] = prio_r[4][6:4];
    prio_vec[15] = prio_r[4][2:0];
    prio_vec[16] = prio_r[5][14:12];
    prio_vec[17] = prio_r[5][10:8];
    prio_vec[18] = prio_r[5][2:0];
    // Their priority fields live in other banks; held at reset level
    prio_vec[19] = prio_t'(`PRIO_ALL_RST >> 12);
    prio_vec[20] = prio_t'(`PRIO_ALL_RST >> 12);
    prio_vec[21] = prio_t'(`PRIO_ALL_RST >> 12);
  end

  // Only the three enable-four sources have an enable in this bank
  always_comb begin
    en_vec     = '1;
    en_vec[19] = enable_four_r[`EN_FAULT_B_BIT];
    en_vec[20] = enable_four_r[`EN_ERROR_B_BIT];
    en_vec[21] = enable_four_r[`EN_SERIAL_ERR_BIT];
  end

  // One gate per source
  generate
    for (genvar i = 0; i < NSRC; i++) begin : g_src
      src_gate u_gate (
        .aclk    (aclk),
        .aresetn (aresetn),
        .flag    (flag_r[i]),
        .enable  (en_vec[i]),
        .prio    (prio_vec[i]),
        .req     (req_w[i]),
        .level   (level_w[i])
      );
      assign core_req[i]           = req_w[i];
      assign core_level[3*i +: 3]  = level_w[i];
    end
  endgenerate

  // Bus write channel state
  logic       aw_held_r;
  logic       w_held_r;
  logic [7:0] waddr_r;
  logic [31:0] wdata_r;
  logic [3:0] wstrb_r;
  logic       do_write;
  logic       wr_hit;

  assign do_write = aw_held_r & w_held_r & ~s_axi_bvalid;

  // Address and data accepted in either order
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_r     <= 1'b0;
      w_held_r      <= 1'b0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      waddr_r       <= 8'h00;
      wdata_r       <= 32'h0000_0000;
      wstrb_r       <= 4'h0;
    end else begin
      s_axi_awready <= ~aw_held_r & ~s_axi_awready & ~s_axi_bvalid;
      s_axi_wready  <= ~w_held_r & ~s_axi_wready & ~s_axi_bvalid;
      if (s_axi_awvalid & s_axi_awready) begin
        aw_held_r <= 1'b1;
        waddr_r   <= s_axi_awaddr;
      end else if (do_write) begin
        aw_held_r <= 1'b0;
      end
      if (s_axi_wvalid & s_axi_wready) begin
        w_held_r <= 1'b1;
        wdata_r  <= s_axi_wdata;
        wstrb_r  <= s_axi_wstrb;
      end else if (do_write) begin
        w_held_r <= 1'b0;
      end
    end
  end

  // Byte-lane merge limited to the implemented bits
  function automatic reg16_t merge(reg16_t old, reg16_t msk);
    reg16_t nv;
    nv = old;
    if (wstrb_r[0]) nv[7:0]  = wdata_r[7:0];
    if (wstrb_r[1]) nv[15:8] = wdata_r[15:8];
    return nv & msk;
  endfunction : merge

  always_comb begin
    case (waddr_r)
      `OFF_ENABLE_FOUR, `OFF_PRIO_ZERO, `OFF_PRIO_ONE, `OFF_PRIO_TWO,
      `OFF_PRIO_THREE, `OFF_PRIO_FOUR, `OFF_PRIO_FIVE, `OFF_FLAG_STATUS,
      `OFF_FLAG_MASK: wr_hit = 1'b1;
      default: wr_hit = 1'b0;
    endcase
  end

  // Configuration registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      enable_four_r <= `ENABLE_FOUR_RST;
      prio_r[0]     <= `PRIO_ALL_RST & `PRIO_ZERO_MASK;
      prio_r[1]     <= `PRIO_ALL_RST & `PRIO_ONE_MASK;
      prio_r[2]     <= `PRIO_ALL_RST & `PRIO_TWO_MASK;
      prio_r[3]     <= `PRIO_ALL_RST & `PRIO_THREE_MASK;
      prio_r[4]     <= `PRIO_ALL_RST & `PRIO_FOUR_MASK;
      prio_r[5]     <= `PRIO_ALL_RST & `PRIO_FIVE_MASK;
      mask_r        <= '0;
    end else if (do_write) begin
      case (waddr_r)
        `OFF_ENABLE_FOUR:
          enable_four_r <= merge(enable_four_r, `ENABLE_FOUR_MASK);
        `OFF_PRIO_ZERO:  prio_r[0] <= merge(prio_r[0], `PRIO_ZERO_MASK);
        `OFF_PRIO_ONE:   prio_r[1] <= merge(prio_r[1], `PRIO_ONE_MASK);
        `OFF_PRIO_TWO:   prio_r[2] <= merge(prio_r[2], `PRIO_TWO_MASK);
        `OFF_PRIO_THREE: prio_r[3] <= merge(prio_r[3], `PRIO_THREE_MASK);
        `OFF_PRIO_FOUR:  prio_r[4] <= merge(prio_r[4], `PRIO_FOUR_MASK);
        `OFF_PRIO_FIVE:  prio_r[5] <= merge(prio_r[5], `PRIO_FIVE_MASK);
        `OFF_FLAG_MASK:
          if (&wstrb_r[2:0]) mask_r <= wdata_r[NSRC-1:0];
        default: ;
      endcase
    end
  end

  // Sticky flags: a new edge wins over a write-one clear
  logic [NSRC-1:0] clr_w;
  assign clr_w = (do_write && waddr_r == `OFF_FLAG_STATUS)
               ? wdata_r[NSRC-1:0] : '0;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      lvl_d_r <= '0;
      flag_r  <= '0;
    end else begin
      lvl_d_r <= lvl;
      flag_r  <= (flag_r & ~clr_w) | (lvl & ~lvl_d_r);
    end
  end

  // Write response one cycle after both halves are in
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= `BUS_OKAY;
    end else if (do_write) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= wr_hit ? `BUS_OKAY : `BUS_DECERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // Read mux; unimplemented bits come back as zero
  logic [31:0] rd_val;
  logic        rd_hit;
  always_comb begin
    rd_val = 32'h0000_0000;
    rd_hit = 1'b1;
    case (s_axi_araddr)
      `OFF_ENABLE_FOUR: rd_val[15:0] = enable_four_r;
      `OFF_PRIO_ZERO:   rd_val[15:0] = prio_r[0];
      `OFF_PRIO_ONE:    rd_val[15:0] = prio_r[1];
      `OFF_PRIO_TWO:    rd_val[15:0] = prio_r[2];
      `OFF_PRIO_THREE:  rd_val[15:0] = prio_r[3];
      `OFF_PRIO_FOUR:   rd_val[15:0] = prio_r[4];
      `OFF_PRIO_FIVE:   rd_val[15:0] = prio_r[5];
      `OFF_FLAG_STATUS: rd_val[NSRC-1:0] = flag_r;
      `OFF_FLAG_MASK:   rd_val[NSRC-1:0] = mask_r;
      `OFF_REQ_STATUS:  rd_val[NSRC-1:0] = req_w;
      default:          rd_hit = 1'b0;
    endcase
  end

  // Read channel: address taken, data one cycle later
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= `BUS_OKAY;
    end else begin
      // Ready pulses only for a waiting address, so none is dropped
      s_axi_arready <= 1'b0;
      if (s_axi_arvalid & s_axi_arready) begin
        s_axi_rvalid  <= 1'b1;
        s_axi_rdata   <= rd_val;
        s_axi_rresp   <= rd_hit ? `BUS_OKAY : `BUS_DECERR;
      end else if (s_axi_rvalid) begin
        if (s_axi_rready) s_axi_rvalid <= 1'b0;
      end else if (s_axi_arvalid) begin
        s_axi_arready <= 1'b1;
      end
    end
  end

  // Summary interrupt from unmasked sticky flags
  always_ff @(posedge aclk) begin
    if (!aresetn) irq <= 1'b0;
    else          irq <= |(flag_r & mask_r);
  end

  // Zero priority never lets a request out
  property p_zero_blocks;
    @(posedge aclk) disable iff (!aresetn)
      (prio_vec[0] == 3'h0) |=> !core_req[0];
  endproperty
  a_zero_prio_blocks: assert property (p_zero_blocks)
    else $error("request with zero priority");

  a_enable_gates_req: assert property (@(posedge aclk)
    disable iff (!aresetn)
    !enable_four_r[`EN_FAULT_B_BIT] |=> !core_req[19])
    else $error("request with enable clear");

  // Source 21 is the one the bench raises before setting its enable
  a_full_req_cause: assert property (@(posedge aclk)
    disable iff (!aresetn)
    (flag_r[21] && en_vec[21] && prio_vec[21] != 3'h0) |=> core_req[21])
    else $error("qualified request missing");

  a_level_follows: assert property (@(posedge aclk)
    disable iff (!aresetn)
    core_req[0] |-> core_level[2:0] == $past(prio_vec[0]))
    else $error("level not priority value");

  a_reserved_zero: assert property (@(posedge aclk)
    disable iff (!aresetn)
    (prio_r[1][3:0] == 4'h0) && (prio_r[5][7:3] == 5'h00))
    else $error("unimplemented bits set");

  // Checked on release, where the reset values must still stand
  a_reset_prio: assert property (@(posedge aclk)
    $rose(aresetn) |-> prio_r[0] == 16'h4444
                    && enable_four_r == 16'h0000)
    else $error("reset values wrong");

  sequence s_rise;
    !lvl_d_r[0] ##0 lvl[0];
  endsequence
  a_flag_on_edge: assert property (@(posedge aclk)
    disable iff (!aresetn) s_rise |=> flag_r[0])
    else $error("flag missed an edge");

  a_low_level_one: assert property (@(posedge aclk)
    disable iff (!aresetn)
    (prio_vec[0] == 3'h1 && flag_r[0]) |=> core_level[2:0] == 3'h1)
    else $error("level one mismatch");

endmodule : irq_enable_priority_bank
`default_nettype wire

// ==== core/src_gate.sv ====
/*
  Per-source request gate: flag, enable and priority combine into a
  registered request. Assumes aclk domain inputs.
*/
`timescale 1ns/1ps
`default_nettype none
module src_gate
  import irq_bank_pkg::*;
(
  // Clock and reset
  input  wire logic  aclk,
  input  wire logic  aresetn,
  // Source state
  input  wire logic  flag,
  input  wire logic  enable,
  input  wire irq_bank_pkg::prio_t prio,
  // Request and its level
  output logic       req,
  output irq_bank_pkg::prio_t level
);
  // Zero priority kills the source whatever its enable or flag
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      req   <= 1'b0;
      level <= 3'h0;
    end else begin
      req   <= flag & enable & (prio != 3'h0);
      level <= (flag & enable) ? prio : 3'h0;
    end
  end
endmodule : src_gate
`default_nettype wire

// ==== dv/irq_enable_priority_bank_tb_top.sv ====
/*
  Self-checking bench for the enable and priority bank over AXI4-Lite.
  Assumes the design files and src_model are compiled first.
*/
`timescale 1ns/1ps
`default_nettype none
`include "irq_bank_consts.svh"
module irq_enable_priority_bank_tb_top;
  import irq_bank_pkg::*;
  logic        aclk, aresetn;
  logic        awvalid, awready, wvalid, wready, bvalid, bready;
  logic        arvalid, arready, rvalid, rready;
  logic [7:0]  awaddr, araddr;
  logic [31:0] wdata, rdata, d;
  logic [3:0]  wstrb;
  logic [1:0]  bresp, rresp, r;
  logic [21:0] src_raw, core_req;
  logic [65:0] core_level;
  logic        irq;
  int          fail_count, comparisons;

  // Bus clock, 40 ns period
  initial aclk = 1'b0;
  always #20 aclk = ~aclk;

  irq_enable_priority_bank DUT (
    .aclk(aclk), .aresetn(aresetn),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_awaddr(awaddr),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_wdata(wdata),
    .s_axi_wstrb(wstrb), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_bresp(bresp), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_araddr(araddr), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .src_raw(src_raw),
    .core_req(core_req), .core_level(core_level), .irq(irq));

  src_model m (.aclk(aclk), .aresetn(aresetn), .src_raw(src_raw));

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : print_verdict

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      fail_count++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic hang();
    fail_count++;
    $display("[ERR] %0t wait ran out", $time);
    print_verdict();
  endtask : hang

  // Address and data offered together, each dropped once taken
  task automatic axw(input logic [7:0] a, input logic [31:0] v);
    int n;
    @(posedge aclk);
    awaddr  <= a;
    wdata   <= v;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      if (bvalid) break;
    end
    if (n == 50) hang();
    r = bresp;
    bready <= 1'b0;
  endtask : axw

  task automatic axr(input logic [7:0] a);
    int n;
    @(posedge aclk);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
      if (rvalid) break;
    end
    if (n == 50) hang();
    d = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask : axr

  // Source index below zero stands for the irq line
  task automatic wait_for(input int i, input logic v);
    int n;
    for (n = 0; n < 40; n++) begin
      if ((i < 0 ? irq : core_req[i]) === v) break;
      @(posedge aclk);
    end
    if (n == 40) hang();
  endtask : wait_for

  logic [7:0]  offs [7] = '{`OFF_ENABLE_FOUR, `OFF_PRIO_ZERO, `OFF_PRIO_ONE,
    `OFF_PRIO_TWO, `OFF_PRIO_THREE, `OFF_PRIO_FOUR, `OFF_PRIO_FIVE};
  logic [15:0] msks [7] = '{`ENABLE_FOUR_MASK, `PRIO_ZERO_MASK,
    `PRIO_ONE_MASK, `PRIO_TWO_MASK, `PRIO_THREE_MASK, `PRIO_FOUR_MASK,
    `PRIO_FIVE_MASK};

  // Reset contents, then all-ones and all-zeros through the seven enable and priority registers
  task automatic t_regs();
    for (int k = 0; k < 7; k++) begin
      axr(offs[k]);
      chk({30'h0, r}, {30'h0, `BUS_OKAY});
      chk(d, {16'h0, (k == 0) ? 16'h0000 : (`PRIO_ALL_RST & msks[k])});
      axw(offs[k], 32'hffff_ffff);
      axr(offs[k]);
      chk(d, {16'h0, msks[k]});
      axw(offs[k], 32'h0);
      axr(offs[k]);
      chk(d, 32'h0);
    end
    $display("test regs done");
  endtask : t_regs

  // Unmapped place refuses both directions
  task automatic t_unmapped();
    axw(8'h28, 32'h1);
    chk({30'h0, r}, {30'h0, `BUS_DECERR});
    axr(8'h28);
    chk({30'h0, r}, {30'h0, `BUS_DECERR});
    $display("test unmapped done");
  endtask : t_unmapped

  // Enable gate on the serial error source, fixed at level four
  task automatic t_enable();
    m.pulse(21);
    repeat (10) @(posedge aclk);
    chk({31'h0, core_req[21]}, 32'h0);
    axr(`OFF_FLAG_STATUS);
    chk({31'h0, d[21]}, 32'h1);
    axw(`OFF_ENABLE_FOUR, 32'h2);
    wait_for(21, 1'b1);
    chk({31'h0, core_req[21]}, 32'h1);
    chk({29'h0, core_level[63 +: 3]}, 32'h4);
    axr(`OFF_REQ_STATUS);
    chk({31'h0, d[21]}, 32'h1);
    axw(`OFF_ENABLE_FOUR, 32'h0);
    wait_for(21, 1'b0);
    chk({31'h0, core_req[21]}, 32'h0);
    $display("test enable done");
  endtask : t_enable

  // Timer one priority at top, bottom and off
  task automatic t_prio();
    axw(`OFF_PRIO_ZERO, 32'h7000);
    m.pulse(0);
    wait_for(0, 1'b1);
    repeat (2) @(posedge aclk);
    chk({29'h0, core_level[2:0]}, 32'h7);
    axw(`OFF_PRIO_ZERO, 32'h1000);
    repeat (3) @(posedge aclk);
    chk({29'h0, core_level[2:0]}, 32'h1);
    chk({31'h0, core_req[0]}, 32'h1);
    axw(`OFF_PRIO_ZERO, 32'h0000);
    wait_for(0, 1'b0);
    chk({31'h0, core_req[0]}, 32'h0);
    axr(`OFF_FLAG_STATUS);
    chk({31'h0, d[0]}, 32'h1);
    $display("test prio done");
  endtask : t_prio

  // Masked and unmasked flags, cleared by writing one
  task automatic t_irq();
    axw(`OFF_FLAG_MASK, 32'h1);
    wait_for(-1, 1'b1);
    chk({31'h0, irq}, 32'h1);
    axw(`OFF_FLAG_STATUS, 32'h0020_0001);
    wait_for(-1, 1'b0);
    axr(`OFF_FLAG_STATUS);
    chk(d, 32'h0);
    axw(`OFF_FLAG_MASK, 32'h0);
    m.pulse(0);
    repeat (6) @(posedge aclk);
    chk({31'h0, irq}, 32'h0);
    $display("test irq done");
  endtask : t_irq

  // Main sequence
  initial begin
    fail_count  = 0;
    comparisons = 0;
    aresetn = 1'b0;
    {awvalid, wvalid, bready, arvalid, rready} = 5'h0;
    awaddr  = 8'h0;
    araddr  = 8'h0;
    wdata   = 32'h0;
    wstrb   = 4'hf;
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (2) @(posedge aclk);
    t_regs();
    t_unmapped();
    t_enable();
    t_prio();
    t_irq();
    print_verdict();
  end
endmodule : irq_enable_priority_bank_tb_top
`default_nettype wire

// ==== dv/src_model.sv ====
/*
  Peripheral side of the bank: raises one request line at a time.
  Assumes the bench calls pulse() from its own thread on aclk.
*/
`timescale 1ns/1ps
`default_nettype none
module src_model (
  // Clock and reset
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // Request lines toward the bank
  output var  logic [21:0] src_raw
);
  initial src_raw = 22'h0;

  // Held four edges so the two-stage synchroniser cannot miss it
  task automatic pulse(input int i);
    @(posedge aclk);
    src_raw[i] <= 1'b1;
    repeat (4) @(posedge aclk);
    src_raw[i] <= 1'b0;
    repeat (2) @(posedge aclk);
  endtask : pulse
endmodule : src_model
`default_nettype wire
